// file: ssp_pkg.sv
package ssp_pkg;
    // Word widths and bit positions
    localparam int unsigned WORD_W = 16;
    localparam logic [4:0] BITS_8 = 5'h08;
    localparam logic [4:0] BITS_16 = 5'h10;
    localparam int unsigned MSB_8 = 7;
    localparam int unsigned MSB_16 = 15;
    // Transmit FIFO shape
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FIFO_AW = 3;
    // Core clock figures
    localparam int unsigned CORE_CLK_MHZ = 50;
    // Core clock to port input clock ratio (one quarter)
    localparam logic [1:0] PORT_CLK_DIV = 2'h3;
    // Reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    // Master sequencer states
    typedef enum logic [1:0]
    {
        SSP_IDLE = 2'b00,
        SSP_LEAD = 2'b01,
        SSP_TRAIL = 2'b10
    } ssp_state_t;
endpackage

// file: ssp_fifo_if.sv
`timescale 1ns/1ns
`default_nettype none
// Stream between the transmit FIFO and the port core
interface ssp_fifo_if;
    logic valid; // Word available
    logic ready; // Consumer takes word
    logic [15:0] data; // Word payload
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: ssp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
// Transmit word FIFO, flip-flop storage
module ssp_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW = 3
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    ssp_fifo_if.src out
);
    // All state of the FIFO
    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } ssp_fifo_st_t;

    ssp_fifo_st_t st_q;
    ssp_fifo_st_t st_d;
    logic push;
    logic pop;

    // Handshakes, honest full and empty
    assign in_ready = (st_q.cnt != (AW+1)'(DEPTH)) && !flush;
    assign out.valid = (st_q.cnt != '0);
    assign out.data = st_q.mem[st_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out.valid && out.ready;

    // Next state
    always_comb
    begin
        st_d = st_q;
        if (flush)
        begin
            st_d.wr = '0;
            st_d.rd = '0;
            st_d.cnt = '0;
        end
        else
        begin
            if (push)
            begin
                st_d.mem[st_q.wr] = in_data;
                st_d.wr = st_q.wr + 1'b1;
            end
            if (pop)
                st_d.rd = st_q.rd + 1'b1;
            st_d.cnt = st_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            st_q <= '0;
        else if (clk_en)
            st_q <= st_d;
    end
endmodule
`default_nettype wire

// file: ssp_div.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage prescaler, one tick per half serial clock period
module ssp_div (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic run,
    input wire logic [1:0] primary_prescale,
    input wire logic [2:0] secondary_prescale,
    output logic half_tick
);
    // All divider state
    typedef struct packed
    {
        logic [1:0] q4;
        logic [5:0] pcnt;
        logic [2:0] scnt;
    } ssp_div_st_t;

    ssp_div_st_t st_q;
    ssp_div_st_t st_d;
    logic [5:0] pri_lim; // Primary terminal count
    logic q4_tick;
    logic p_tick;

    // Primary ratio 64,16,4,1 for codes 0..3; secondary 8-code
    always_comb
    begin
        unique case (primary_prescale)
            2'h0: pri_lim = 6'h3F;
            2'h1: pri_lim = 6'h0F;
            2'h2: pri_lim = 6'h03;
            2'h3: pri_lim = 6'h00;
        endcase
    end

    assign q4_tick = (st_q.q4 == ssp_pkg::PORT_CLK_DIV);
    assign p_tick = q4_tick && (st_q.pcnt == pri_lim);
    assign half_tick = p_tick && (st_q.scnt == ~secondary_prescale);

    // Count chain, held clear when not running
    always_comb
    begin
        st_d = st_q;
        if (!run)
            st_d = '0;
        else
        begin
            st_d.q4 = st_q.q4 + 1'b1;
            if (q4_tick)
                st_d.pcnt = (st_q.pcnt == pri_lim) ? 6'h00 : st_q.pcnt + 1'b1;
            if (half_tick)
                st_d.scnt = 3'h0;
            else if (p_tick)
                st_d.scnt = st_q.scnt + 1'b1;
        end
    end

    // Registers
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            st_q <= '0;
        else if (clk_en)
            st_q <= st_d;
    end
endmodule
`default_nettype wire

// file: ssp_core.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - 16-bit shift register plus software buffer
// - Four pins: in, out, clock, select
// - Master drives shift clock, slave receives it
// - 8 or 16 pulses, full duplex shifting
// - Completion sets flag, enable gates interrupt
// - Complete received word copied to buffer
// - Unread buffer: set overflow, drop word
// - Overflow ignores clock until buffer read
// - Pending transmit word loads after transfer
// - One address: write transmit, read receive
// - Master prescales clock, starts on write
// - Master interrupt mid last bit
// - Slave interrupt when last bit latched
// - Select high in slave mode: no transfer, output off
// - Input clock quarter rate, two prescalers
// - Edge select picks slave data change edge; master data changes on trailing edge
// - Polarity sets clock idle level
// - Out from bit 7/15, in at 0
// - Select high in slave mode resets counters and control
// - Idle-stop bit halts port in idle
module ssp_core (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic port_enable,
    input wire logic master_mode,
    input wire logic word_width_select,
    input wire logic clock_edge_select,
    input wire logic clock_idle_level,
    input wire logic select_control_enable,
    input wire logic [1:0] primary_prescale,
    input wire logic [2:0] secondary_prescale,
    input wire logic idle_stop_select,
    input wire logic cpu_idle,
    input wire logic port1_irq_enable,
    input wire logic flag_clear,
    input wire logic buf_wr,
    input wire logic [15:0] buf_wdata,
    input wire logic buf_rd,
    output logic buf_wr_ready,
    output logic [15:0] shared_buffer_reg,
    output logic rx_full,
    output logic rx_overflow_flag,
    output logic port1_irq_flag,
    output logic irq,
    output logic busy,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic shift_clock_in,
    output logic shift_clock_out,
    output logic shift_clock_oe,
    input wire logic slave_select_n
);
    // All port state
    typedef struct packed
    {
        ssp_pkg::ssp_state_t st;
        logic [15:0] sr; // serial_shift_reg
        logic [15:0] rxb; // rx_holding_buffer
        logic rx_full;
        logic ovf;
        logic irqf;
        logic [4:0] cnt; // Bits completed
        logic sck; // Master clock level, active when set
        logic sin; // Sampled bit awaiting shift
        logic sout; // Output bit register
        logic loaded; // Shift register holds a word to send
        logic sck_prev; // Slave clock previous level
        logic width_prev; // Width seen last cycle
    } ssp_st_t;

    ssp_st_t st_q;
    ssp_st_t st_d;
    ssp_fifo_if tx_if (); // tx_holding_buffer stream
    logic half_tick;
    logic active; // Port permitted to run
    logic sel_ok; // Select allows transfer
    logic [4:0] nbits; // Bits per transfer
    logic [3:0] msb; // Output bit index
    logic s_rise;
    logic s_fall;
    logic s_lead; // Slave idle-to-active edge
    logic s_trail; // Slave active-to-idle edge
    logic s_sample; // Slave sample edge
    logic s_shift; // Slave shift-out edge
    logic done; // Word complete this cycle
    logic [15:0] shifted;

    // Transmit FIFO between software and shift register
    ssp_fifo #(
        .WIDTH(ssp_pkg::WORD_W),
        .DEPTH(ssp_pkg::FIFO_DEPTH),
        .AW(ssp_pkg::FIFO_AW)
    ) u_txq (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .flush(!port_enable),
        .in_valid(buf_wr),
        .in_ready(buf_wr_ready),
        .in_data(buf_wdata),
        .out(tx_if.src)
    );

    // Serial clock prescaler
    ssp_div u_div (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .run(active && master_mode && (st_q.st != ssp_pkg::SSP_IDLE)),
        .primary_prescale(primary_prescale),
        .secondary_prescale(secondary_prescale),
        .half_tick(half_tick)
    );

    // Run conditions
    assign active = port_enable && !(idle_stop_select && cpu_idle);
    assign sel_ok = !select_control_enable || !slave_select_n;
    assign nbits = word_width_select ? ssp_pkg::BITS_16 : ssp_pkg::BITS_8;
    assign msb = word_width_select ? 4'(ssp_pkg::MSB_16) : 4'(ssp_pkg::MSB_8);
    assign shifted = {st_q.sr[14:0], st_q.sin};

    // Slave clock edges, pins synchronous to core clock
    assign s_rise = shift_clock_in && !st_q.sck_prev;
    assign s_fall = !shift_clock_in && st_q.sck_prev;
    assign s_lead = clock_idle_level ? s_fall : s_rise;
    assign s_trail = clock_idle_level ? s_rise : s_fall;
    assign s_sample = clock_edge_select ? s_lead : s_trail;
    assign s_shift = clock_edge_select ? s_trail : s_lead;

    // Outputs
    assign shared_buffer_reg = st_q.rxb;
    assign rx_full = st_q.rx_full;
    assign rx_overflow_flag = st_q.ovf;
    assign port1_irq_flag = st_q.irqf;
    assign irq = st_q.irqf && port1_irq_enable;
    assign busy = st_q.st != ssp_pkg::SSP_IDLE;
    assign serial_out_pin = st_q.sout;
    assign serial_out_oe = active && (master_mode || sel_ok);
    assign shift_clock_out = st_q.sck ^ clock_idle_level;
    assign shift_clock_oe = active && master_mode;

    // Next-state logic
    always_comb
    begin
        st_d = st_q;
        done = 1'b0;
        tx_if.ready = 1'b0;
        st_d.sck_prev = shift_clock_in;
        st_d.width_prev = word_width_select;
        // Software read empties buffer and frees the port
        if (buf_rd)
        begin
            st_d.rx_full = 1'b0;
            st_d.ovf = 1'b0;
        end
        if (flag_clear)
            st_d.irqf = 1'b0;
        if (!active || (st_q.width_prev != word_width_select))
        begin
            // Disabled or width changed: sequencer reset
            st_d.st = ssp_pkg::SSP_IDLE;
            st_d.cnt = ssp_pkg::CNT_RST;
            st_d.sck = 1'b0;
            st_d.loaded = 1'b0;
        end
        else if (master_mode)
        begin
            // Master: begin when a word is queued
            unique case (st_q.st)
                ssp_pkg::SSP_IDLE:
                begin
                    st_d.sck = 1'b0;
                    if (tx_if.valid && !st_q.ovf)
                    begin
                        tx_if.ready = 1'b1;
                        st_d.sr = tx_if.data;
                        st_d.sout = tx_if.data[msb];
                        st_d.cnt = ssp_pkg::CNT_RST;
                        st_d.st = ssp_pkg::SSP_LEAD;
                    end
                end
                ssp_pkg::SSP_LEAD:
                begin
                    // First half: clock goes active, sample
                    if (half_tick)
                    begin
                        st_d.sck = 1'b1;
                        st_d.sin = serial_in_pin;
                        st_d.st = ssp_pkg::SSP_TRAIL;
                        if (st_q.cnt == nbits - 5'h01)
                            done = 1'b1;
                    end
                end
                ssp_pkg::SSP_TRAIL:
                begin
                    // Second half: clock idles, shift
                    if (half_tick)
                    begin
                        st_d.sck = 1'b0;
                        st_d.sr = shifted;
                        st_d.cnt = st_q.cnt + 5'h01;
                        st_d.sout = st_q.sr[msb - 4'h1];
                        if (st_q.cnt == nbits - 5'h01)
                            st_d.st = ssp_pkg::SSP_IDLE;
                        else
                            st_d.st = ssp_pkg::SSP_LEAD;
                    end
                end
                default:
                    st_d.st = ssp_pkg::SSP_IDLE;
            endcase
        end
        else if (select_control_enable && slave_select_n)
        begin
            // Select high: restart from the MSB next time
            st_d.cnt = ssp_pkg::CNT_RST;
            st_d.st = ssp_pkg::SSP_IDLE;
            st_d.loaded = 1'b0;
        end
        else if (!st_q.ovf)
        begin
            // Slave: preload transmit word when idle
            if (!st_q.loaded && st_q.cnt == ssp_pkg::CNT_RST && tx_if.valid)
            begin
                tx_if.ready = 1'b1;
                st_d.sr = tx_if.data;
                st_d.sout = tx_if.data[msb];
                st_d.loaded = 1'b1;
            end
            else if (s_sample)
            begin
                st_d.sr = {st_q.sr[14:0], serial_in_pin};
                st_d.st = ssp_pkg::SSP_TRAIL;
                if (st_q.cnt == nbits - 5'h01)
                begin
                    done = 1'b1;
                    st_d.cnt = ssp_pkg::CNT_RST;
                    st_d.loaded = 1'b0;
                    st_d.st = ssp_pkg::SSP_IDLE;
                end
                else
                    st_d.cnt = st_q.cnt + 5'h01;
            end
            else if (s_shift && st_q.cnt != ssp_pkg::CNT_RST)
                st_d.sout = st_q.sr[msb];
        end
        // Completion: copy to receive buffer or flag overflow
        if (done)
        begin
            st_d.irqf = 1'b1;
            if (st_q.rx_full && !buf_rd)
                st_d.ovf = 1'b1;
            else
            begin
                // Whole word, including the bit latched this cycle
                st_d.rxb = {st_q.sr[14:0], serial_in_pin};
                st_d.rx_full = 1'b1;
            end
        end
        // Master receive word rewritten after final shift only if buffer was read since completion
        if (master_mode && st_q.st == ssp_pkg::SSP_TRAIL && half_tick
            && st_q.cnt == nbits - 5'h01 && !st_q.ovf && !st_q.rx_full)
            st_d.rxb = shifted;
        // Narrow words read zero above
        if (!word_width_select)
            st_d.rxb[15:8] = 8'h00;
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            st_q <= '0;
        else if (clk_en)
            st_q <= st_d;
    end
endmodule
`default_nettype wire

// file: ssp_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level properties of the serial port core
module ssp_core_asserts (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic master_mode,
    input wire logic select_control_enable,
    input wire logic slave_select_n,
    input wire logic clock_idle_level,
    input wire logic port1_irq_enable,
    input wire logic flag_clear,
    input wire logic buf_rd,
    input wire logic [15:0] shared_buffer_reg,
    input wire logic rx_full,
    input wire logic rx_overflow_flag,
    input wire logic port1_irq_flag,
    input wire logic irq,
    input wire logic busy,
    input wire logic shift_clock_out,
    input wire logic shift_clock_oe,
    input wire logic serial_out_oe
);
    // One domain, one reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    irq_gate_a:
        assert property (irq == (port1_irq_flag && port1_irq_enable)) else $error("irq differs from flag and enable");
    clk_dir_a:
        assert property (!master_mode |-> !shift_clock_oe) else $error("slave drives shift clock");
    sel_off_a:
        assert property (!master_mode && select_control_enable && slave_select_n |-> !serial_out_oe)
            else $error("data out driven while deselected");
    idle_level_a:
        assert property (master_mode && !busy && !$past(busy) |-> shift_clock_out == clock_idle_level)
            else $error("shift clock not at idle level");
    ovf_hold_a:
        assert property (rx_overflow_flag && !buf_rd |=> $stable(shared_buffer_reg))
            else $error("buffer changed during overflow");
    ovf_pause_a:
        assert property (rx_overflow_flag && $past(rx_overflow_flag) && !$past(busy) |-> $stable(shift_clock_out))
            else $error("shift clock moved during overflow");
    ovf_cause_a:
        assert property ($rose(rx_overflow_flag) |-> rx_full && $past(rx_full))
            else $error("overflow without full buffer");
    read_clear_a:
        assert property (buf_rd && !busy |=> !rx_full && !rx_overflow_flag)
            else $error("buffer read left flags set");
    flag_mid_a:
        assert property ($rose(port1_irq_flag) && master_mode |-> busy && shift_clock_out != clock_idle_level)
            else $error("flag rose outside last bit");
    flag_clear_a:
        assert property (flag_clear && !busy |=> !port1_irq_flag) else $error("flag not cleared");
endmodule
`default_nettype wire

// file: ssp_peer.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side serial slave answering the port's master clock
module ssp_peer (
    input wire logic core_clk,
    input wire logic sck,
    input wire logic idle_lvl,
    input wire logic sout,
    input wire logic load,
    input wire logic wide,
    input wire logic [15:0] tx_word,
    output logic sin,
    output logic [15:0] rx_word
);
    logic sck_q = 1'b0; // Clock seen last cycle
    logic [4:0] idx = 5'h00; // Bits already sent
    logic [4:0] top; // Index of first bit sent
    assign top = wide ? 5'h0F : 5'h07;
    // MSB first, then the inverse of the last bit once done
    assign sin = (idx <= top) ? tx_word[top[3:0] - idx[3:0]] : ~tx_word[0];
    // Sample on leading edge, advance on trailing edge
    always @(posedge core_clk)
    begin
        sck_q <= sck;
        if (load)
        begin
            idx <= 5'h00;
            rx_word <= 16'h0000;
        end
        else if (sck != sck_q && sck_q == idle_lvl)
            rx_word <= {rx_word[14:0], sout};
        else if (sck != sck_q && idx <= top)
            idx <= idx + 5'h01;
    end
endmodule
`default_nettype wire

// file: test_serial_peripheral_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_serial_peripheral_port;
    // Clock, reset and control levels
    logic core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, port_enable = 1'b1, master_mode = 1'b1;
    logic word_width_select = 1'b0, clock_edge_select = 1'b0, clock_idle_level = 1'b0;
    logic select_control_enable = 1'b0, idle_stop_select = 1'b0, cpu_idle = 1'b0;
    logic port1_irq_enable = 1'b0, flag_clear = 1'b0, buf_wr = 1'b0, buf_rd = 1'b0;
    logic shift_clock_in = 1'b0, slave_select_n = 1'b1, peer_load = 1'b0;
    logic [1:0] primary_prescale = 2'h3;
    logic [2:0] secondary_prescale = 3'h7;
    logic [15:0] buf_wdata = 16'h0000, peer_word = 16'h0000;
    // Design and peer outputs
    logic buf_wr_ready, rx_full, rx_overflow_flag, port1_irq_flag, irq, busy;
    logic serial_in_pin, serial_out_pin, serial_out_oe, shift_clock_out, shift_clock_oe;
    logic [15:0] shared_buffer_reg, peer_rx;
    int errors = 0, comparisons = 0;

    // 50 MHz core clock
    always #10 core_clk = ~core_clk;

    ssp_core i_dut (.core_clk, .reset_n, .clk_en, .port_enable, .master_mode, .word_width_select,
        .clock_edge_select, .clock_idle_level, .select_control_enable, .primary_prescale,
        .secondary_prescale, .idle_stop_select, .cpu_idle, .port1_irq_enable, .flag_clear, .buf_wr,
        .buf_wdata, .buf_rd, .buf_wr_ready, .shared_buffer_reg, .rx_full, .rx_overflow_flag,
        .port1_irq_flag, .irq, .busy, .serial_in_pin, .serial_out_pin, .serial_out_oe, .shift_clock_in,
        .shift_clock_out, .shift_clock_oe, .slave_select_n);
    ssp_peer i_peer (.core_clk, .sck(shift_clock_out), .idle_lvl(clock_idle_level), .sout(serial_out_pin),
        .load(peer_load), .wide(word_width_select), .tx_word(peer_word), .sin(serial_in_pin), .rx_word(peer_rx));

    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        begin
            comparisons++;
            if (got !== exp)
            begin
                errors++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Counts, verdict, end of run
    task automatic wrap_up();
        begin
            $display("errors %0d comparisons %0d", errors, comparisons);
            if (errors == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // Wait conditions by number
    function automatic logic cond(input int k);
        case (k)
            0: return port1_irq_flag === 1'b1;
            1: return rx_full === 1'b1;
            3: return rx_overflow_flag === 1'b1;
            default: return busy === 1'b0;
        endcase
    endfunction

    // Bounded wait, at least one edge
    task automatic wait_on(input int k);
        int n;
        begin
            n = 0;
            do
            begin
                @(posedge core_clk);
                #1;
                n++;
            end
            while (!cond(k) && n < 3000);
            if (n == 3000)
                check(16'h0000, 16'h0001);
        end
    endtask

    // Offer n words in a row, count the accepted ones
    task automatic put(input logic [15:0] base, input int n, output int taken);
        begin
            taken = 0;
            buf_wr = 1'b1;
            for (int i = 0; i < n; i++)
            begin
                buf_wdata = base + i[15:0];
                if (buf_wr_ready === 1'b1)
                    taken++;
                @(posedge core_clk);
                #1;
            end
            buf_wr = 1'b0;
        end
    endtask

    // Software read of the shared buffer
    task automatic rd();
        begin
            buf_rd = 1'b1;
            @(posedge core_clk);
            #1;
            buf_rd = 1'b0;
        end
    endtask

    // Reconfigure with the port off, arm the peer
    task automatic setup(input logic wide, input logic lvl, input logic [15:0] ptx);
        begin
            word_width_select = wide;
            clock_idle_level = lvl;
            peer_word = ptx;
            port_enable = 1'b0;
            peer_load = 1'b1;
            @(posedge core_clk);
            #1;
            port_enable = 1'b1;
            peer_load = 1'b0;
        end
    endtask

    // Levels straight after reset
    task automatic after_reset();
        begin
            check({10'h000, buf_wr_ready, busy, rx_full, rx_overflow_flag, port1_irq_flag, shift_clock_out}, 16'h0020);
            check(shared_buffer_reg, 16'h0000);
        end
    endtask

    // One master transfer, both directions checked
    task automatic xfer(input logic wide, input logic lvl, input logic en, input logic [15:0] tx,
        input logic [15:0] ptx);
        int taken;
        logic [15:0] mask;
        begin
            mask = wide ? 16'hFFFF : 16'h00FF;
            port1_irq_enable = en;
            setup(wide, lvl, ptx);
            put(tx, 1, taken);
            wait_on(0);
            check({15'h0000, irq}, {15'h0000, en});
            wait_on(2);
            check(peer_rx, tx & mask);
            check(shared_buffer_reg, ptx & mask);
            check({15'h0000, rx_full}, 16'h0001);
            flag_clear = 1'b1;
            rd();
            flag_clear = 1'b0;
            check({14'h0000, rx_full, port1_irq_flag}, 16'h0000);
        end
    endtask

    // Overflow stalls the port while the FIFO fills, then drains
    task automatic overflow_fill();
        int taken;
        begin
            setup(1'b1, 1'b1, 16'h5A3C);
            put(16'h0101, 2, taken);
            wait_on(3);
            check(shared_buffer_reg, 16'h5A3C);
            put(16'h0200, 10, taken);
            check(taken[15:0], 16'h0008);
            check({14'h0000, busy, buf_wr_ready}, 16'h0000);
            rd();
            repeat (8)
            begin
                wait_on(1);
                rd();
            end
            wait_on(2);
            check({13'h0000, rx_full, rx_overflow_flag, buf_wr_ready}, 16'h0001);
            check(shared_buffer_reg, 16'hFFFF);
        end
    endtask

    // Slave select gates the data output, then one slave byte
    task automatic slave_select();
        int taken;
        logic [7:0] tx;
        begin
            tx = 8'h96;
            master_mode = 1'b0;
            select_control_enable = 1'b1;
            clock_edge_select = 1'b1;
            flag_clear = 1'b1;
            setup(1'b0, 1'b0, 16'h0000);
            flag_clear = 1'b0;
            check({14'h0000, serial_out_oe, shift_clock_oe}, 16'h0000);
            put({8'h00, tx}, 1, taken);
            slave_select_n = 1'b0;
            @(posedge core_clk);
            #1;
            check({15'h0000, serial_out_oe}, 16'h0001);
            // Sample on rising, shift on falling edge
            for (int i = 7; i >= 0; i--)
            begin
                check({15'h0000, serial_out_pin}, {15'h0000, tx[i]});
                shift_clock_in = 1'b1;
                repeat (2) @(posedge core_clk);
                #1;
                shift_clock_in = 1'b0;
                repeat (2) @(posedge core_clk);
                #1;
            end
            check(shared_buffer_reg, 16'h0000);
            check({14'h0000, rx_full, port1_irq_flag}, 16'h0003);
            // Idle stop turns the port off
            idle_stop_select = 1'b1;
            cpu_idle = 1'b1;
            @(posedge core_clk);
            #1;
            check({15'h0000, serial_out_oe}, 16'h0000);
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        after_reset();
        xfer(1'b0, 1'b0, 1'b0, 16'h00A5, 16'hFF3C);
        xfer(1'b1, 1'b1, 1'b1, 16'hC3A5, 16'h5A0F);
        overflow_fill();
        slave_select();
        wrap_up();
    end

    // Watchdog: about ten times the expected run
    initial
    begin
        #400000;
        errors++;
        wrap_up();
    end
endmodule

bind ssp_core ssp_core_asserts u_chk (.core_clk, .reset_n, .master_mode, .select_control_enable,
    .slave_select_n, .clock_idle_level, .port1_irq_enable, .flag_clear, .buf_rd, .shared_buffer_reg,
    .rx_full, .rx_overflow_flag, .port1_irq_flag, .irq, .busy, .shift_clock_out, .shift_clock_oe,
    .serial_out_oe);
`default_nettype wire
